//--- video_monitor_pkg.sv
package video_monitor_pkg;

	// ==========================================================
	// Register map
	localparam logic [2:0] ADDR_IDENTITY       = 3'h0;
	localparam logic [2:0] ADDR_BUILD_INFO_A   = 3'h1;
	localparam logic [2:0] ADDR_BUILD_INFO_B   = 3'h2;
	localparam logic [2:0] ADDR_BUILD_INFO_C   = 3'h3;
	localparam logic [2:0] ADDR_CAPTURE_SELECT = 3'h4;
	localparam logic [2:0] ADDR_SAMPLE_SPACING = 3'h5;

	localparam logic [31:0] CAPTURE_SELECT_RESET = 32'h0000_0000;
	localparam logic [31:0] SAMPLE_SPACING_RESET = 32'h0000_0000;

	// ==========================================================
	// Field positions
	localparam int CTRL_ENABLE_BIT = 0;
	localparam int CTRL_STATS_BIT  = 8;
	localparam int CTRL_BEATS_BIT  = 9;
	localparam int CTRL_PIXEL_BIT  = 10;
	localparam int ID_MAKER_W      = 12;
	localparam int ID_MONITOR_W    = 16;
	localparam int MASK_LSB        = 0;
	localparam int GAP_LSB         = 16;
	localparam int SPACING_W       = 16;

	// ==========================================================
	// Capture records
	localparam int          MAX_BEATS   = 6;
	localparam int          STATS_WORDS = 3;
	localparam int          REC_WORDS   = 1 + STATS_WORDS + MAX_BEATS;
	localparam logic [7:0]  TAG_PACKET  = 8'hA1;
	localparam logic [7:0]  TAG_PIXEL   = 8'hA2;
	localparam logic [3:0]  VIDEO_TYPE  = 4'h0;
	localparam int          RATE_SCALE  = 1000000;

	// ==========================================================
	// Sample placement generator
	localparam logic [15:0] LFSR_SEED = 16'hACE1;
	localparam logic [15:0] LFSR_TAPS = 16'hB400;

	typedef struct packed {
		logic [2:0]  addr;
		logic        read;
		logic        write;
		logic [31:0] wdata;
	} reg_req_t;

	typedef enum logic {EMIT_IDLE, EMIT_SEND} emit_state_t;

endpackage

//--- video_stream_monitor.sv
module video_stream_monitor #(
	parameter int          BPP        = 8,
	parameter int          PLANES     = 3,
	parameter bit          PARALLEL   = 1'b1,
	parameter int          PPB        = 1,
	parameter int          CAP_W      = 32,
	parameter bit          CAP_PIX    = 1'b0,
	// Arbitrary identity values
	parameter logic [11:0] MAKER_ID   = 12'h5A3,
	parameter logic [15:0] MONITOR_ID = 16'h0C71,
	localparam int         DIN_W      = BPP * (PARALLEL ? PLANES : 1) * PPB
) (
	input  wire logic                          clock,
	input  wire logic                          clk_en,
	input  wire logic                          sys_rst,
	input  wire video_monitor_pkg::reg_req_t   reg_req,
	output logic      [31:0]                   reg_rdata,
	input  wire logic [DIN_W-1:0]              din_data,
	input  wire logic                          din_valid,
	input  wire logic                          din_sop,
	input  wire logic                          din_eop,
	output logic                               din_ready,
	output logic      [DIN_W-1:0]              dout_data,
	output logic                               dout_valid,
	output logic                               dout_sop,
	output logic                               dout_eop,
	input  wire logic                          dout_ready,
	output logic      [CAP_W-1:0]              cap_data,
	output logic                               cap_valid,
	output logic                               cap_sop,
	output logic                               cap_eop,
	input  wire logic                          cap_ready
);

	// ==========================================================
	// Derived sizes
	// Pixel capture gate
	localparam bit PIX_OK = CAP_PIX && (PPB == 1);
	localparam int PIXW   = BPP * PLANES;
	localparam int PAD_W  = (DIN_W > PIXW) ? ((DIN_W > 32) ? DIN_W : 32) : ((PIXW > 32) ? PIXW : 32);
	localparam int OUT_W  = (CAP_W > 32) ? CAP_W : 32;
	localparam int SUBS   = (CAP_W >= 32) ? 1 : 32 / CAP_W;
	localparam int SUB_W  = (SUBS > 1) ? $clog2(SUBS) : 1;

	typedef struct packed {
		logic [31:0]                      ctrl;
		logic [31:0]                      spacing;
		logic [31:0]                      rdata;
		logic                             in_pkt;
		logic                             is_video;
		logic [31:0]                      n_xfer;
		logic [31:0]                      n_stall;
		logic [31:0]                      n_idle_bp;
		logic [3:0]                       n_beats;
		logic [video_monitor_pkg::MAX_BEATS-1:0][31:0] beats;
		logic [15:0]                      lfsr;
		logic [16:0]                      skip;
		logic [1:0]                       plane;
		logic [PIXW-1:0]                  pix_acc;
		logic                             pix_pend;
		logic [31:0]                      pix_val;
		logic [31:0]                      pix_pos;
		logic [31:0]                      pix_pos_hit;
		video_monitor_pkg::emit_state_t   emit;
		logic [video_monitor_pkg::REC_WORDS-1:0][31:0] rec;
		logic [3:0]                       rec_len;
		logic [3:0]                       widx;
		logic [SUB_W-1:0]                 sidx;
		logic [CAP_W-1:0]                 cdata;
		logic                             cvalid;
		logic                             csop;
		logic                             ceop;
	} state_t;

	state_t           st_q;
	state_t           st_d;
	logic             xfer;
	logic             cap_on;
	logic             stats_on;
	logic             beats_on;
	logic             pix_on;
	logic             pix_take;
	logic             pkt_load;
	logic [PAD_W-1:0] din_pad;
	logic [PIXW-1:0]  pixel;
	logic [PAD_W-1:0] pixel_pad;
	logic [31:0]      id_word;
	logic [31:0]      info_a;
	logic [31:0]      info_b;
	logic [31:0]      info_c;

	function automatic logic [CAP_W-1:0] beat_of(input logic [31:0] w, input logic [SUB_W-1:0] s);
		logic [OUT_W-1:0] wide;
		wide = OUT_W'(w) >> (int'(s) * CAP_W);
		return wide[CAP_W-1:0];
	endfunction

	// ==========================================================
	// Stream tap
	// Combinational pass-through
	assign dout_data  = din_data;
	assign dout_valid = din_valid;
	assign dout_sop   = din_sop;
	assign dout_eop   = din_eop;
	assign din_ready  = dout_ready;
	assign xfer       = din_valid && dout_ready;
	assign din_pad    = PAD_W'(din_data);

	assign cap_on   = st_q.ctrl[video_monitor_pkg::CTRL_ENABLE_BIT];
	assign stats_on = cap_on && st_q.ctrl[video_monitor_pkg::CTRL_STATS_BIT];
	assign beats_on = cap_on && st_q.ctrl[video_monitor_pkg::CTRL_BEATS_BIT];
	// Pixel hardware present only if built
	assign pix_on   = PIX_OK && cap_on && st_q.ctrl[video_monitor_pkg::CTRL_PIXEL_BIT];

	// ==========================================================
	// Identity and build information
	// Identity fields
	assign id_word = {4'h0, MONITOR_ID, MAKER_ID};
	assign info_a  = {8'(PPB), 7'h00, PARALLEL, 8'(PLANES), 8'(BPP)};
	assign info_b  = 32'(CAP_W);
	assign info_c  = {30'h0000_0000, PIX_OK, CAP_PIX};

	// Pixel assembly per plane arrangement
	// Built from st_q so next-state logic never loops on itself
	assign pixel     = PARALLEL ? din_pad[PIXW-1:0]
		: ((st_q.pix_acc >> BPP) | (PIXW'(din_data[BPP-1:0]) << (PIXW - BPP)));
	assign pixel_pad = PAD_W'(pixel);

	// ==========================================================
	// Next state
	always_comb
	begin
		int k;
		logic [3:0] idx;
		logic       pix_done;
		k        = 1;
		idx      = 4'h0;
		pix_done = 1'b0;
		st_d     = st_q;
		pix_take = 1'b0;
		pkt_load = 1'b0;
		st_d.lfsr = {st_q.lfsr[14:0], ^(st_q.lfsr & video_monitor_pkg::LFSR_TAPS)};

		if (reg_req.write)
		begin
			if (reg_req.addr == video_monitor_pkg::ADDR_CAPTURE_SELECT)
				st_d.ctrl = reg_req.wdata;
			if (reg_req.addr == video_monitor_pkg::ADDR_SAMPLE_SPACING)
				st_d.spacing = reg_req.wdata;
		end
		if (reg_req.read)
		begin
			unique case (reg_req.addr)
				video_monitor_pkg::ADDR_IDENTITY:       st_d.rdata = id_word;
				video_monitor_pkg::ADDR_BUILD_INFO_A:   st_d.rdata = info_a;
				video_monitor_pkg::ADDR_BUILD_INFO_B:   st_d.rdata = info_b;
				video_monitor_pkg::ADDR_BUILD_INFO_C:   st_d.rdata = info_c;
				video_monitor_pkg::ADDR_CAPTURE_SELECT: st_d.rdata = st_q.ctrl;
				video_monitor_pkg::ADDR_SAMPLE_SPACING: st_d.rdata = st_q.spacing;
				default:                                st_d.rdata = 32'h0000_0000;
			endcase
		end

		if (xfer)
			st_d.n_xfer = st_q.n_xfer + 32'h0000_0001;
		if (din_valid && !dout_ready)
		begin
			if (st_q.in_pkt)
				st_d.n_stall = st_q.n_stall + 32'h0000_0001;
			else
				st_d.n_idle_bp = st_q.n_idle_bp + 32'h0000_0001;
		end

		// Keep up to six opening beats
		if (xfer)
		begin
			idx = din_sop ? 4'h0 : st_q.n_beats;
			if (idx < 4'(video_monitor_pkg::MAX_BEATS))
			begin
				st_d.beats[idx[2:0]] = din_pad[31:0];
				st_d.n_beats         = idx + 4'h1;
			end
		end
		if (xfer && din_sop)
		begin
			st_d.in_pkt   = 1'b1;
			st_d.is_video = (din_data[3:0] == video_monitor_pkg::VIDEO_TYPE);
			st_d.plane    = 2'h0;
			st_d.pix_pos  = 32'h0000_0000;
		end

		if (xfer && !din_sop && st_q.in_pkt && st_q.is_video && pix_on)
		begin
			st_d.pix_acc = (st_q.pix_acc >> BPP) | (PIXW'(din_data[BPP-1:0]) << (PIXW - BPP));
			pix_done     = PARALLEL || (st_q.plane == 2'(PLANES - 1));
			st_d.plane   = pix_done ? 2'h0 : st_q.plane + 2'h1;
		end
		if (pix_done)
		begin
			st_d.pix_pos = st_q.pix_pos + 32'h0000_0001;
			// Skip count sets how many pixels pass before the next sample
			if (st_q.skip == 17'h0_0000)
			begin
				pix_take = 1'b1;
				st_d.skip = 17'(st_q.spacing[video_monitor_pkg::GAP_LSB +: video_monitor_pkg::SPACING_W])
					+ 17'(st_q.lfsr & st_q.spacing[video_monitor_pkg::MASK_LSB +: video_monitor_pkg::SPACING_W]);
			end
			else
				st_d.skip = st_q.skip - 17'h0_0001;
		end

		// ======================================================
		// Capture emitter
		// Capture source handshake
		if (st_q.cvalid && cap_ready)
		begin
			if (st_q.ceop)
			begin
				st_d.cvalid = 1'b0;
				st_d.emit   = video_monitor_pkg::EMIT_IDLE;
			end
			else
			begin
				if (st_q.sidx == SUB_W'(SUBS - 1))
				begin
					st_d.sidx = '0;
					st_d.widx = st_q.widx + 4'h1;
				end
				else
					st_d.sidx = st_q.sidx + SUB_W'(1);
				st_d.cdata = beat_of(st_q.rec[st_d.widx], st_d.sidx);
				st_d.csop  = 1'b0;
				st_d.ceop  = (st_d.widx == st_q.rec_len - 4'h1) && (st_d.sidx == SUB_W'(SUBS - 1));
			end
		end

		// Packet records arriving while busy are dropped so the tap never stalls
		if (xfer && din_eop)
		begin
			st_d.in_pkt   = 1'b0;
			st_d.is_video = 1'b0;
			if ((stats_on || beats_on) && st_q.emit == video_monitor_pkg::EMIT_IDLE)
			begin
				pkt_load = 1'b1;
				if (stats_on)
				begin
					st_d.rec[1] = st_d.n_xfer;
					st_d.rec[2] = st_d.n_stall;
					st_d.rec[3] = st_d.n_idle_bp;
					k = 1 + video_monitor_pkg::STATS_WORDS;
				end
				if (beats_on)
				begin
					for (int i = 0; i < video_monitor_pkg::MAX_BEATS; i++)
						if (4'(i) < st_d.n_beats)
							st_d.rec[4'(k + i)] = st_d.beats[i];
					k = k + int'(st_d.n_beats);
				end
				st_d.rec_len = 4'(k);
				st_d.rec[0]  = {video_monitor_pkg::TAG_PACKET, 4'h0, st_d.n_beats,
					6'h00, beats_on, stats_on, 4'h0, st_d.rec_len};
			end
			st_d.n_xfer    = 32'h0000_0000;
			st_d.n_stall   = 32'h0000_0000;
			st_d.n_idle_bp = 32'h0000_0000;
		end
		else if (st_q.pix_pend && pix_on && st_q.emit == video_monitor_pkg::EMIT_IDLE)
		begin
			pkt_load      = 1'b1;
			st_d.pix_pend = 1'b0;
			st_d.rec[0]   = {video_monitor_pkg::TAG_PIXEL, 20'h0_0000, 4'h3};
			st_d.rec[1]   = st_q.pix_pos_hit;
			st_d.rec[2]   = st_q.pix_val;
			st_d.rec_len  = 4'h3;
		end
		if (pkt_load)
		begin
			st_d.emit   = video_monitor_pkg::EMIT_SEND;
			st_d.widx   = 4'h0;
			st_d.sidx   = '0;
			st_d.cdata  = beat_of(st_d.rec[0], '0);
			st_d.cvalid = 1'b1;
			st_d.csop   = 1'b1;
			// Every record has at least two words
			st_d.ceop   = 1'b0;
		end

		// New sample wins over the clear of the last one
		if (pix_take)
		begin
			st_d.pix_pend    = 1'b1;
			st_d.pix_val     = pixel_pad[31:0];
			st_d.pix_pos_hit = st_q.pix_pos;
		end
	end

	// ==========================================================
	// State register
	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			st_q         <= '0;
			st_q.ctrl    <= video_monitor_pkg::CAPTURE_SELECT_RESET;
			st_q.spacing <= video_monitor_pkg::SAMPLE_SPACING_RESET;
			st_q.lfsr    <= video_monitor_pkg::LFSR_SEED;
			st_q.emit    <= video_monitor_pkg::EMIT_IDLE;
		end
		else if (clk_en)
			st_q <= st_d;
	end

	assign reg_rdata = st_q.rdata;
	assign cap_data  = st_q.cdata;
	assign cap_valid = st_q.cvalid;
	assign cap_sop   = st_q.csop;
	assign cap_eop   = st_q.ceop;

	// ==========================================================
	// Checks
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (sys_rst);

	property p_pass_through;
		dout_valid == din_valid && dout_data == din_data && din_ready == dout_ready;
	endproperty
	a_pass_through: assert property (p_pass_through) else $error("stream altered");

	property p_xfer_count;
		clk_en && xfer && !din_eop |=> st_q.n_xfer == $past(st_q.n_xfer) + 32'h0000_0001;
	endproperty
	a_xfer_count: assert property (p_xfer_count) else $error("transfer count slip");

	property p_idle_bp;
		clk_en && !st_q.in_pkt && din_valid && !dout_ready && !(xfer && din_eop)
			|=> st_q.n_idle_bp == $past(st_q.n_idle_bp) + 32'h0000_0001;
	endproperty
	a_idle_bp: assert property (p_idle_bp) else $error("inter-packet count slip");

	property p_disabled_silent;
		!cap_on && !cap_valid |=> !cap_valid;
	endproperty
	a_disabled_silent: assert property (p_disabled_silent) else $error("record while disabled");

	property p_beat_limit;
		st_q.n_beats <= 4'(video_monitor_pkg::MAX_BEATS);
	endproperty
	a_beat_limit: assert property (p_beat_limit) else $error("beat store overrun");

	property p_next_gap;
		clk_en && pix_take |=> st_q.skip == 17'($past(st_q.spacing[31:16])) + 17'($past(st_q.lfsr)
			& $past(st_q.spacing[15:0]));
	endproperty
	a_next_gap: assert property (p_next_gap) else $error("sample distance wrong");

	property p_identity;
		clk_en && reg_req.read && reg_req.addr == video_monitor_pkg::ADDR_IDENTITY
			|=> reg_rdata == {4'h0, MONITOR_ID, MAKER_ID};
	endproperty
	a_identity: assert property (p_identity) else $error("identity word wrong");

	property p_cap_hold;
		cap_valid && !cap_ready |=> cap_valid && $stable(cap_data) && $stable(cap_sop);
	endproperty
	a_cap_hold: assert property (p_cap_hold) else $error("capture beat dropped");

	property p_ctrl_write;
		clk_en && reg_req.write && reg_req.addr == video_monitor_pkg::ADDR_CAPTURE_SELECT
			|=> st_q.ctrl == $past(reg_req.wdata);
	endproperty
	a_ctrl_write: assert property (p_ctrl_write) else $error("control write lost");

	property p_no_pixel_hw;
		!PIX_OK |-> !st_q.pix_pend;
	endproperty
	a_no_pixel_hw: assert property (p_no_pixel_hw) else $error("pixel without hardware");

	c_packet_record: cover property (cap_valid && cap_ready && cap_sop && cap_data != '0);
	c_pixel_take: cover property (pix_take);
	c_backpressure: cover property (din_valid && !dout_ready ##1 xfer);

endmodule

//--- trace_sink_model.sv
module trace_sink_model (
	input  wire logic        clock,
	input  wire logic        sys_rst,
	input  wire logic        slow,
	input  wire logic [31:0] cap_data,
	input  wire logic        cap_valid,
	input  wire logic        cap_sop,
	input  wire logic        cap_eop,
	output logic             cap_ready
);
	timeunit 1ns;
	timeprecision 100ps;

	logic [31:0] words[$];
	logic [31:0] held_q;
	logic        wait_q;
	logic [1:0]  pace_q;
	int          hold_errs;
	int          rec_total;
	int          eop_total;

	// ==========================================================
	// Record collection
	// Slow mode gives one ready cycle in four, so every beat after a record's first waits
	// records from capture port
	always @(posedge clock)
	begin
		if (sys_rst)
		begin
			pace_q    <= 2'h0;
			wait_q    <= 1'b0;
			cap_ready <= 1'b0;
			hold_errs <= 0;
			rec_total <= 0;
			eop_total <= 0;
		end
		else
		begin
			pace_q    <= pace_q + 2'h1;
			cap_ready <= !slow || pace_q == 2'h3;
			wait_q    <= cap_valid && !cap_ready;
			held_q    <= cap_data;
			if (wait_q && (cap_valid !== 1'b1 || cap_data !== held_q))
				hold_errs <= hold_errs + 1;
			if (cap_valid && cap_ready)
			begin
				words.push_back(cap_data);
				if (cap_sop)
					rec_total <= rec_total + 1;
				if (cap_eop)
					eop_total <= eop_total + 1;
			end
		end
	end
endmodule

//--- video_stream_monitor_capture_bench.sv
`define CHK(got, exp) \
	begin \
		checks_done++; \
		if ((got) !== (exp)) \
		begin \
			err_total++; \
			$display("unexpected at %0t: got %h, expected %h", $time, got, exp); \
		end \
	end

module video_stream_monitor_capture_bench;
	timeunit 1ns;
	timeprecision 100ps;

	// Arbitrary identity values
	localparam logic [11:0] MAK_ID = 12'h2B4;
	localparam logic [15:0] MON_ID = 16'h0D15;

	logic                          clock;
	logic                          clk_en;
	logic                          sys_rst;
	logic                          slow;
	video_monitor_pkg::reg_req_t   req;
	logic [31:0]                   reg_rdata;
	logic [23:0]                   din_data;
	logic                          din_valid;
	logic                          din_sop;
	logic                          din_eop;
	logic                          din_ready;
	logic [23:0]                   dout_data;
	logic                          dout_valid;
	logic                          dout_sop;
	logic                          dout_eop;
	logic                          dout_ready;
	logic [31:0]                   cap_data;
	logic                          cap_valid;
	logic                          cap_sop;
	logic                          cap_eop;
	logic                          cap_ready;
	int                            err_total;
	int                            checks_done;

	video_stream_monitor #(.CAP_W(32), .CAP_PIX(1'b1), .MAKER_ID(MAK_ID), .MONITOR_ID(MON_ID)) dut_u (
		.clock(clock), .clk_en(clk_en), .sys_rst(sys_rst), .reg_req(req), .reg_rdata(reg_rdata),
		.din_data(din_data), .din_valid(din_valid), .din_sop(din_sop), .din_eop(din_eop),
		.din_ready(din_ready), .dout_data(dout_data), .dout_valid(dout_valid),
		.dout_sop(dout_sop), .dout_eop(dout_eop), .dout_ready(dout_ready),
		.cap_data(cap_data), .cap_valid(cap_valid), .cap_sop(cap_sop), .cap_eop(cap_eop),
		.cap_ready(cap_ready)
	);

	trace_sink_model model_u (
		.clock(clock), .sys_rst(sys_rst), .slow(slow), .cap_data(cap_data),
		.cap_valid(cap_valid), .cap_sop(cap_sop), .cap_eop(cap_eop), .cap_ready(cap_ready)
	);

	always #2.5 clock = ~clock;

	// ==========================================================
	// Helpers
	task automatic stop_test();
		if (err_total == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic step();
		@(posedge clock);
		#1;
	endtask

	function automatic logic [23:0] dat(input int i);
		return 24'h30_0000 + 24'(i * 17);
	endfunction

	// Idle edge after each request so a strobe never toggles twice in one step
	task automatic reg_wr(input logic [2:0] a, input logic [31:0] d);
		req.addr = a;
		req.wdata = d;
		req.write = 1'b1;
		step();
		req.write = 1'b0;
		step();
	endtask

	task automatic reg_rd(input logic [2:0] a, output logic [31:0] d);
		req.addr = a;
		req.read = 1'b1;
		step();
		req.read = 1'b0;
		d = reg_rdata;
		step();
	endtask

	// One cycle on the tap; the pass-through is judged combinationally
	task automatic beat(input logic [23:0] d, input logic v, s, e, r);
		din_data = d;
		din_valid = v;
		din_sop = s;
		din_eop = e;
		dout_ready = r;
		#1;
		`CHK({dout_data, dout_valid, dout_sop, dout_eop, din_ready}, {d, v, s, e, r})
		step();
	endtask

	// Waits for eight quiet cycles on the capture port
	task automatic drain();
		int idle;
		int n;
		idle = 0;
		n = 0;
		while (idle < 8)
		begin
			idle = (cap_valid === 1'b0) ? idle + 1 : 0;
			n++;
			if (n > 2000)
			begin
				err_total++;
				$display("unexpected at %0t: capture port never went quiet", $time);
				stop_test();
			end
			step();
		end
	endtask

	// ==========================================================
	// Scenarios
	task automatic reg_case();
		logic [31:0] d;
		reg_wr(video_monitor_pkg::ADDR_IDENTITY, 32'hFFFF_FFFF);
		reg_rd(video_monitor_pkg::ADDR_IDENTITY, d);
		`CHK(d, {4'h0, MON_ID, MAK_ID})
		reg_rd(video_monitor_pkg::ADDR_BUILD_INFO_A, d);
		`CHK(d, 32'h0101_0308)
		reg_rd(video_monitor_pkg::ADDR_BUILD_INFO_B, d);
		`CHK(d, 32'h0000_0020)
		reg_rd(video_monitor_pkg::ADDR_BUILD_INFO_C, d);
		`CHK(d, 32'h0000_0003)
		reg_rd(3'h6, d);
		`CHK(d, 32'h0000_0000)
		// Frozen clock enable must swallow the write
		clk_en = 1'b0;
		reg_wr(video_monitor_pkg::ADDR_CAPTURE_SELECT, 32'h0000_0301);
		clk_en = 1'b1;
		reg_rd(video_monitor_pkg::ADDR_CAPTURE_SELECT, d);
		`CHK(d, video_monitor_pkg::CAPTURE_SELECT_RESET)
		reg_wr(video_monitor_pkg::ADDR_SAMPLE_SPACING, 32'h00C7_00F0);
		reg_rd(video_monitor_pkg::ADDR_SAMPLE_SPACING, d);
		`CHK(d, 32'h00C7_00F0)
	endtask

	task automatic pkt_case(input logic [31:0] ctrl, input int n, pre, mid, nw, input logic sl);
		int base;
		reg_wr(video_monitor_pkg::ADDR_CAPTURE_SELECT, ctrl);
		slow = sl;
		model_u.words = {};
		for (int i = 0; i < pre; i++)
			beat(dat(0), 1'b1, 1'b1, 1'b0, 1'b0);
		for (int i = 0; i < n; i++)
		begin
			if (i == 1)
				for (int k = 0; k < mid; k++)
					beat(dat(1), 1'b1, 1'b0, 1'b0, 1'b0);
			beat(dat(i), 1'b1, i == 0, i == n - 1, 1'b1);
		end
		beat(24'h00_0000, 1'b0, 1'b0, 1'b0, 1'b1);
		drain();
		`CHK(model_u.words.size(), nw)
		if (nw > 0)
		begin
			`CHK(model_u.words[0][31:16], {8'hA1, 4'h0, 4'((n < 6) ? n : 6)})
			`CHK(model_u.words[0][9:8], ctrl[9:8])
			`CHK(model_u.words[0][3:0], 4'(nw))
			base = ctrl[8] ? 4 : 1;
			if (ctrl[8])
			begin
				`CHK(model_u.words[1], n)
				`CHK(model_u.words[2], mid)
				`CHK(model_u.words[3], pre)
			end
			for (int i = 0; ctrl[9] && i < n && i < 6; i++)
				`CHK(model_u.words[base + i], {8'h00, dat(i)})
		end
	endtask

	// With a mask only the spacing bounds are judged, the start depends on history
	task automatic pix_case(input logic [15:0] gap, mask, input int npix);
		int          k;
		logic [31:0] last;
		logic [31:0] pos;
		k = 0;
		last = 32'h0000_0000;
		reg_wr(video_monitor_pkg::ADDR_SAMPLE_SPACING, {gap, mask});
		reg_wr(video_monitor_pkg::ADDR_CAPTURE_SELECT, 32'h0000_0401);
		slow = 1'b0;
		model_u.words = {};
		beat(24'h00_0000, 1'b1, 1'b1, 1'b0, 1'b1);
		for (int i = 0; i < npix; i++)
		begin
			beat(24'h10_0000 + 24'(i), 1'b1, 1'b0, i == npix - 1, 1'b1);
			repeat (3)
				beat(24'h00_0000, 1'b0, 1'b0, 1'b0, 1'b1);
		end
		drain();
		for (int j = 0; j + 2 < model_u.words.size(); j++)
			if (model_u.words[j] === 32'hA200_0003)
			begin
				pos = model_u.words[j + 1];
				if (mask == 16'h0000)
					`CHK(pos, 32'(k * (gap + 1)))
				else if (k > 0)
				begin
					`CHK(pos - last >= gap + 1, 1'b1)
					`CHK(pos - last <= gap + mask + 1, 1'b1)
				end
				`CHK(model_u.words[j + 2], 32'h0010_0000 + pos)
				last = pos;
				k++;
			end
		if (mask == 16'h0000)
			`CHK(k, (npix - 1) / (gap + 1) + 1)
		else
			`CHK(k > 1, 1'b1)
	endtask

	// ==========================================================
	// Main sequence
	initial
	begin
		clock = 1'b0;
		clk_en = 1'b1;
		sys_rst = 1'b1;
		slow = 1'b0;
		req = '0;
		din_data = 24'h00_0000;
		din_valid = 1'b0;
		din_sop = 1'b0;
		din_eop = 1'b0;
		dout_ready = 1'b1;
		err_total = 0;
		checks_done = 0;
		repeat (12)
			@(posedge clock);
		#1;
		sys_rst = 1'b0;
		reg_case();
		pkt_case(32'h0000_0300, 4, 1, 1, 0, 1'b0);
		pkt_case(32'h0000_0301, 8, 2, 3, 10, 1'b0);
		pkt_case(32'h0000_0101, 3, 1, 0, 4, 1'b0);
		pkt_case(32'h0000_0201, 8, 0, 0, 7, 1'b1);
		pix_case(16'h0000, 16'h0000, 3);
		pix_case(16'h00C7, 16'h0000, 401);
		pix_case(16'h0010, 16'h000F, 300);
		`CHK(model_u.hold_errs, 0)
		`CHK(model_u.eop_total, model_u.rec_total)
		stop_test();
	end
endmodule
